/* File: common/gio_pkg.sv */
// Function
// - Input pins read back their level after synchronising to the clock.
// - Output pins read back the level the block itself drives.
// - Open-drain pins read back the real wired level of the line.
// - Software or emulator reset leaves pin configuration and outputs untouched.
// - Power-controller reset returns all configuration registers to defaults.
// - Hardware reset returns configuration and data registers to defaults.
// - Bank enable bit 0 gates events from pins 15 to 0.
// - Each pin triggers on rising, falling, both or no edge.
// - Edge detection works on clock-synchronised pin values.
// - Writing 1 to a trigger-set bit enables that pin edge.
// - Writing 1 to a trigger-clear bit disables that pin edge.
// - Edges raise events whatever the pin direction.
// - Pending register shows 1 for pending pins, 0 otherwise.
// - Writing 1 clears a pending flag; writing 0 leaves it.
// - Per-pin and per-bank interrupt outputs both exist.
// - Events also go out as DMA synchronisation events.
// - Low-power state suspends interrupt generation until it ends.
// - Low-power state holds output pins at their prior levels.
// - Emulation halts and breakpoints do not affect the block.
// - Ident register: scheme 01, function 27-16, revision and custom below.
// - Direction 0 means output, 1 input; all pins input after reset.
// - Output latch reads return the latch, not the pin.
// - Bank enable bit 1 gates interrupt and DMA events of bank 1.
package gio_pkg;
    localparam int NPIN = 32;
    localparam int BANK_W = 16;

    ////////////////////////////////////////////////////////////////////////////
    // Register byte addresses
    localparam logic [7:0] OFS_IDENT      = 8'h00;
    localparam logic [7:0] OFS_BANK_EN    = 8'h08;
    localparam logic [7:0] OFS_DIR        = 8'h10;
    localparam logic [7:0] OFS_LATCH      = 8'h14;
    localparam logic [7:0] OFS_OUT_SET    = 8'h18;
    localparam logic [7:0] OFS_OUT_CLR    = 8'h1C;
    localparam logic [7:0] OFS_IN_STATE   = 8'h20;
    localparam logic [7:0] OFS_RISE_SET   = 8'h24;
    localparam logic [7:0] OFS_RISE_CLR   = 8'h28;
    localparam logic [7:0] OFS_FALL_SET   = 8'h2C;
    localparam logic [7:0] OFS_FALL_CLR   = 8'h30;
    localparam logic [7:0] OFS_PENDING    = 8'h34;

    ////////////////////////////////////////////////////////////////////////////
    // Values after reset
    localparam logic [31:0] DIR_RST     = 32'hFFFF_FFFF;
    localparam logic [31:0] LATCH_RST   = 32'h0000_0000;
    localparam logic [31:0] TRIG_RST    = 32'h0000_0000;
    localparam logic [31:0] PEND_RST    = 32'h0000_0000;
    localparam logic [1:0]  BANK_EN_RST = 2'h0;

    ////////////////////////////////////////////////////////////////////////////
    // Ident field layout
    localparam logic [1:0] IDENT_SCHEME = 2'h1;
    localparam int IDENT_SCHEME_LSB = 30;
    localparam int IDENT_FUNC_LSB   = 16;
    localparam int IDENT_DESIGN_LSB = 11;
    localparam int IDENT_MAJOR_LSB  = 8;
    localparam int IDENT_CUSTOM_LSB = 6;
    localparam int IDENT_MINOR_LSB  = 0;

    typedef struct packed {
        logic [31:0] meta;
        logic [31:0] stage;
        logic [31:0] prev;
    } gio_sync_state_t;

    typedef struct packed {
        logic [31:0] dir;
        logic [31:0] latch;
        logic [31:0] rise_en;
        logic [31:0] fall_en;
        logic [31:0] pend;
        logic [1:0]  bank_en;
        logic [31:0] pin_out;
        logic [31:0] pin_oe_n;
        logic [31:0] pin_irq;
        logic [31:0] dma_evt;
        logic [1:0]  bank_irq;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } gio_state_t;
endpackage

/* File: design/gio_pin_sync.sv */
module gio_pin_sync (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [31:0] level_in,
    output logic      [31:0] synced,
    output logic      [31:0] rise,
    output logic      [31:0] fall
);
    gio_pkg::gio_sync_state_t q;
    gio_pkg::gio_sync_state_t next_q;

    // Two-stage synchroniser, then one stage of history for edges
    always_comb begin
        next_q       = q;
        next_q.meta  = level_in;
        next_q.stage = q.meta;
        next_q.prev  = q.stage;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign synced = q.stage;
    assign rise   = q.stage & ~q.prev;
    assign fall   = ~q.stage & q.prev;
endmodule

/* File: design/gio_top.sv */
// Added by the designer: the APB register port.
module gio_top #(
    parameter logic [11:0] IDENT_FUNC   = 12'hA5C,  // Arbitrary value
    parameter logic [4:0]  IDENT_DESIGN = 5'h0,     // Arbitrary value
    parameter logic [2:0]  IDENT_MAJOR  = 3'h2,     // Arbitrary value
    parameter logic [1:0]  IDENT_CUSTOM = 2'h0,     // Arbitrary value
    parameter logic [5:0]  IDENT_MINOR  = 6'h3      // Arbitrary value
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        pwr_reset,
    input  wire logic        low_power,
    input  wire logic [31:0] od_mask,
    input  wire logic [31:0] general_pins_in,
    output logic      [31:0] general_pins_out,
    output logic      [31:0] general_pins_oe_n,
    output logic      [31:0] pin_irq,
    output logic      [1:0]  bank_irq,
    output logic      [31:0] dma_evt
);
    gio_pkg::gio_state_t q;
    gio_pkg::gio_state_t next_q;

    logic [31:0] sense_level;
    logic [31:0] in_state;
    logic [31:0] rise;
    logic [31:0] fall;
    logic [31:0] ident;
    logic [31:0] edge_hit;
    logic [31:0] bank_mask;
    logic [31:0] events;
    logic [31:0] read_word;
    logic        addr_hit;
    logic        setup;
    logic        wr_acc;

    ////////////////////////////////////////////////////////////////////////////
    // Pin sensing

    // Push-pull outputs sense own drive; inputs and open drain sense the line
    assign sense_level = ((q.dir | od_mask) & general_pins_in)
                       | (~(q.dir | od_mask) & q.pin_out);

    gio_pin_sync u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .level_in (sense_level),
        .synced   (in_state),
        .rise     (rise),
        .fall     (fall)
    );

    assign ident = {gio_pkg::IDENT_SCHEME, 2'h0, IDENT_FUNC, IDENT_DESIGN,
                    IDENT_MAJOR, IDENT_CUSTOM, IDENT_MINOR};

    ////////////////////////////////////////////////////////////////////////////
    // Edge events

    // No halt or breakpoint input exists: event flow never stops for debug
    assign edge_hit  = ((rise & q.rise_en) | (fall & q.fall_en))
                     & {32{~low_power}};
    assign bank_mask = {{gio_pkg::BANK_W{q.bank_en[1]}},
                        {gio_pkg::BANK_W{q.bank_en[0]}}};
    assign events    = edge_hit & bank_mask;

    ////////////////////////////////////////////////////////////////////////////
    // Register read decode

    always_comb begin
        read_word = 32'h0000_0000;
        addr_hit  = 1'b1;
        case (paddr)
            gio_pkg::OFS_IDENT: begin
                read_word = ident;
            end
            gio_pkg::OFS_BANK_EN: begin
                read_word = {30'h0, q.bank_en};
            end
            gio_pkg::OFS_DIR: begin
                read_word = q.dir;
            end
            gio_pkg::OFS_LATCH, gio_pkg::OFS_OUT_SET, gio_pkg::OFS_OUT_CLR: begin
                read_word = q.latch;
            end
            gio_pkg::OFS_IN_STATE: begin
                read_word = in_state;
            end
            gio_pkg::OFS_RISE_SET, gio_pkg::OFS_RISE_CLR: begin
                read_word = q.rise_en;
            end
            gio_pkg::OFS_FALL_SET, gio_pkg::OFS_FALL_CLR: begin
                read_word = q.fall_en;
            end
            gio_pkg::OFS_PENDING: begin
                read_word = q.pend;
            end
            default: begin
                addr_hit = 1'b0;
            end
        endcase
    end

    assign setup  = psel & ~penable;
    assign wr_acc = psel & penable & q.pready & pwrite & ~q.pslverr;

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        next_q         = q;
        next_q.pready  = 1'b0;
        next_q.pslverr = 1'b0;
        if (setup) begin
            next_q.pready  = 1'b1;
            next_q.pslverr = ~addr_hit;
            next_q.prdata  = pwrite ? 32'h0000_0000 : read_word;
        end

        if (wr_acc) begin
            case (paddr)
                gio_pkg::OFS_BANK_EN: begin
                    next_q.bank_en = pwdata[1:0];
                end
                gio_pkg::OFS_DIR: begin
                    next_q.dir = pwdata;
                end
                gio_pkg::OFS_LATCH: begin
                    next_q.latch = (q.latch & q.dir) | (pwdata & ~q.dir);
                end
                gio_pkg::OFS_OUT_SET: begin
                    next_q.latch = q.latch | (pwdata & ~q.dir);
                end
                gio_pkg::OFS_OUT_CLR: begin
                    next_q.latch = q.latch & ~(pwdata & ~q.dir);
                end
                gio_pkg::OFS_RISE_SET: begin
                    next_q.rise_en = q.rise_en | pwdata;
                end
                gio_pkg::OFS_RISE_CLR: begin
                    next_q.rise_en = q.rise_en & ~pwdata;
                end
                gio_pkg::OFS_FALL_SET: begin
                    next_q.fall_en = q.fall_en | pwdata;
                end
                gio_pkg::OFS_FALL_CLR: begin
                    next_q.fall_en = q.fall_en & ~pwdata;
                end
                gio_pkg::OFS_PENDING: begin
                    next_q.pend = q.pend & ~pwdata;
                end
                default: begin
                    next_q.bank_en = q.bank_en;
                end
            endcase
        end

        // New edge wins over a clear in the same cycle
        next_q.pend = next_q.pend | edge_hit;

        // Config back to defaults; output latch kept
        if (pwr_reset) begin
            next_q.dir     = gio_pkg::DIR_RST;
            next_q.rise_en = gio_pkg::TRIG_RST;
            next_q.fall_en = gio_pkg::TRIG_RST;
            next_q.pend    = gio_pkg::PEND_RST;
            next_q.bank_en = gio_pkg::BANK_EN_RST;
        end

        next_q.pin_irq  = events;
        next_q.dma_evt  = events;
        next_q.bank_irq = {|events[31:16], |events[15:0]};

        // Pins frozen while in low power
        if (!low_power) begin
            next_q.pin_out  = next_q.latch & ~od_mask;
            next_q.pin_oe_n = next_q.dir | (od_mask & next_q.latch);
        end else begin
            next_q.pin_out  = q.pin_out;
            next_q.pin_oe_n = q.pin_oe_n;
        end
    end

    // Only presetn clears data; nothing else reaches the latch
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q          <= '0;
            q.dir      <= gio_pkg::DIR_RST;
            q.latch    <= gio_pkg::LATCH_RST;
            q.pin_oe_n <= 32'hFFFF_FFFF;
        end else begin
            q <= next_q;
        end
    end

    assign prdata            = q.prdata;
    assign pready            = q.pready;
    assign pslverr           = q.pslverr;
    assign general_pins_out  = q.pin_out;
    assign general_pins_oe_n = q.pin_oe_n;
    assign pin_irq           = q.pin_irq;
    assign bank_irq          = q.bank_irq;
    assign dma_evt           = q.dma_evt;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    chk_pend_on_edge: assert property (
        !pwr_reset && |edge_hit |=> (q.pend & $past(edge_hit)) == $past(edge_hit)
    ) else $error("enabled edge did not set pending flag");

    chk_pend_w1c: assert property (
        wr_acc && paddr == gio_pkg::OFS_PENDING && edge_hit == 32'h0 && !pwr_reset
        |=> q.pend == ($past(q.pend) & ~$past(pwdata))
    ) else $error("pending write-one-clear wrong");

    chk_rise_w1s: assert property (
        wr_acc && paddr == gio_pkg::OFS_RISE_SET && !pwr_reset
        |=> q.rise_en == ($past(q.rise_en) | $past(pwdata))
    ) else $error("rise trigger set wrong");

    chk_fall_w1c: assert property (
        wr_acc && paddr == gio_pkg::OFS_FALL_CLR && !pwr_reset
        |=> q.fall_en == ($past(q.fall_en) & ~$past(pwdata))
    ) else $error("fall trigger clear wrong");

    chk_lp_no_irq: assert property (
        low_power |=> pin_irq == 32'h0 && bank_irq == 2'h0 && dma_evt == 32'h0
    ) else $error("event during low power");

    chk_lp_pins_hold: assert property (
        low_power |=> general_pins_out == $past(general_pins_out)
                      && general_pins_oe_n == $past(general_pins_oe_n)
    ) else $error("pins moved in low power");

    chk_bank_any: assert property (
        bank_irq[0] == |pin_irq[15:0] && bank_irq[1] == |pin_irq[31:16]
    ) else $error("bank interrupt disagrees with pin interrupts");

    chk_bank_gate: assert property (
        !q.bank_en[1] |=> pin_irq[31:16] == 16'h0 && dma_evt[31:16] == 16'h0
    ) else $error("bank 1 event while disabled");

    chk_pwr_default: assert property (
        pwr_reset |=> q.dir == gio_pkg::DIR_RST && q.rise_en == 32'h0
                      && q.pend == 32'h0 && q.bank_en == 2'h0
    ) else $error("power reset left config");

    chk_ident_read: assert property (
        setup && !pwrite && paddr == gio_pkg::OFS_IDENT
        |=> pready && prdata[31:30] == 2'h1 && prdata[29:28] == 2'h0
    ) else $error("ident scheme wrong");

    chk_apb_answer: assert property (
        setup |=> pready ##1 !pready
    ) else $error("ready not one cycle after setup");

    cov_pend_set: cover property (|edge_hit ##1 |q.pend);
    cov_bank_irq: cover property (|bank_irq);
    cov_lp_entry: cover property (!low_power ##1 low_power);
    cov_bad_addr: cover property (pslverr && pready);
endmodule

/* File: sim/gio_pin_model.sv */
module gio_pin_model (
    input  wire logic        pclk,
    input  wire logic [31:0] drv_out,
    input  wire logic [31:0] drv_oe_n,
    input  wire logic [31:0] od_mask,
    input  wire logic [31:0] ext_val,
    input  wire logic [31:0] ext_en,
    output logic      [31:0] line
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] churn = 32'h0000_0000;
    logic [31:0] far;
    // Undriven push-pull lines never settle
    always @(posedge pclk) churn <= ~churn;
    assign far = (ext_en & ext_val) | (~ext_en & od_mask) | (~ext_en & ~od_mask & churn);
    // Open-drain lines are wired-AND with a pull-up
    assign line = (od_mask & drv_oe_n & far)
                | (~od_mask & ((~drv_oe_n & drv_out) | (drv_oe_n & far)));
endmodule

/* File: sim/tb.sv */
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [11:0] FUNC  = 12'h3C7;  // Arbitrary value
    localparam logic [2:0]  MAJOR = 3'h4;     // Arbitrary value
    localparam logic [5:0]  MINOR = 6'h2A;    // Arbitrary value
    localparam logic [31:0] IDENT = {2'h1, 2'h0, FUNC, 5'h0, MAJOR, 2'h0, MINOR};
    logic        pclk      = 1'b0;
    logic        presetn   = 1'b0;
    logic        psel      = 1'b0;
    logic        penable   = 1'b0;
    logic        pwrite    = 1'b0;
    logic [7:0]  paddr     = 8'h00;
    logic [31:0] pwdata    = 32'h0;
    logic        pwr_reset = 1'b0;
    logic        low_power = 1'b0;
    logic [31:0] od_mask   = 32'h0;
    logic [31:0] ext_val   = 32'h0;
    logic [31:0] ext_en    = 32'hFFFF_FFFF;
    logic        seen_clr  = 1'b0;
    logic [31:0] prdata, line, pins_out, pins_oe_n, pin_irq, dma_evt, seen_pin, seen_dma, rd;
    logic [1:0]  bank_irq, seen_bank;
    logic        pready, pslverr, err;
    int          failures  = 0;
    int          tests_run = 0;

    always #25 pclk = ~pclk;
    always @(posedge pclk) begin
        if (seen_clr) begin
            seen_pin  <= 32'h0;
            seen_dma  <= 32'h0;
            seen_bank <= 2'h0;
        end else begin
            seen_pin  <= seen_pin | pin_irq;
            seen_dma  <= seen_dma | dma_evt;
            seen_bank <= seen_bank | bank_irq;
        end
    end

    gio_top #(.IDENT_FUNC(FUNC), .IDENT_MAJOR(MAJOR), .IDENT_MINOR(MINOR)) gio_top_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pwr_reset(pwr_reset), .low_power(low_power), .od_mask(od_mask),
        .general_pins_in(line), .general_pins_out(pins_out), .general_pins_oe_n(pins_oe_n),
        .pin_irq(pin_irq), .bank_irq(bank_irq), .dma_evt(dma_evt));

    gio_pin_model gio_pin_model_inst (
        .pclk(pclk), .drv_out(pins_out), .drv_oe_n(pins_oe_n), .od_mask(od_mask),
        .ext_val(ext_val), .ext_en(ext_en), .line(line));

    ////////////////////////////////////////////////////////////////////////////
    task automatic results();
        $display("comparisons %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            failures++;
            results();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rc(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rd, exp);
    endtask

    task automatic clr();
        @(posedge pclk);
        seen_clr <= 1'b1;
        @(posedge pclk);
        seen_clr <= 1'b0;
    endtask

    task automatic edge_to(input logic [31:0] v);
        clr();
        @(posedge pclk);
        ext_val <= v;
        repeat (8) @(posedge pclk);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5000) @(posedge pclk);
        failures++;
        results();
    end

    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rc(8'h00, IDENT);
        wr(8'h00, 32'hFFFF_FFFF);
        rc(8'h00, IDENT);
        rc(8'h10, 32'hFFFF_FFFF);
        rc(8'h14, 32'h0);
        rc(8'h08, 32'h0);
        rc(8'h24, 32'h0);
        rc(8'h34, 32'h0);
        apb(1'b0, 8'h0C, 32'h0);
        check({31'h0, err}, 32'h1);
        // Bank 0 output, bank 1 input
        wr(8'h10, 32'hFFFF_0000);
        wr(8'h14, 32'h1234_5678);
        ext_val <= 32'hABCD_0000;
        rc(8'h14, 32'h0000_5678);
        repeat (4) @(posedge pclk);
        check(pins_oe_n, 32'hFFFF_0000);
        check(pins_out, 32'h0000_5678);
        rc(8'h20, 32'hABCD_5678);
        wr(8'h18, 32'h0000_8001);
        wr(8'h1C, 32'h0000_0070);
        rc(8'h14, 32'h0000_D609);
        // Pin 0 open drain, far end released to its pull-up
        od_mask <= 32'h1;
        ext_en <= 32'hFFFF_FFFE;
        repeat (4) @(posedge pclk);
        check(pins_oe_n, 32'hFFFF_0001);
        check(pins_out, 32'h0000_D608);
        rc(8'h20, 32'hABCD_D609);
        wr(8'h1C, 32'h1);
        repeat (4) @(posedge pclk);
        rc(8'h20, 32'hABCD_D608);
        wr(8'h18, 32'h1);
        od_mask <= 32'h0;
        ext_en <= 32'hFFFF_FFFF;
        // Edge triggers on bank 1 inputs
        wr(8'h24, 32'h0001_0000);
        wr(8'h2C, 32'h0002_0000);
        wr(8'h08, 32'h2);
        rc(8'h24, 32'h0001_0000);
        rc(8'h2C, 32'h0002_0000);
        edge_to(32'hABCE_0000);
        rc(8'h34, 32'h0);
        edge_to(32'hABCD_0000);
        rc(8'h34, 32'h0003_0000);
        check(seen_pin, 32'h0003_0000);
        check(seen_dma, 32'h0003_0000);
        check({30'h0, seen_bank}, 32'h2);
        wr(8'h34, 32'h0);
        rc(8'h34, 32'h0003_0000);
        wr(8'h34, 32'h0001_0000);
        rc(8'h34, 32'h0002_0000);
        wr(8'h34, 32'h0002_0000);
        wr(8'h28, 32'h0001_0000);
        rc(8'h24, 32'h0);
        edge_to(32'hABCE_0000);
        edge_to(32'hABCD_0000);
        rc(8'h34, 32'h0002_0000);
        wr(8'h34, 32'hFFFF_FFFF);
        // Output pin 3 toggled by software, bank 0 gated off then enabled
        wr(8'h24, 32'h8);
        wr(8'h2C, 32'h8);
        clr();
        wr(8'h1C, 32'h8);
        repeat (8) @(posedge pclk);
        rc(8'h34, 32'h8);
        check(seen_pin, 32'h0);
        check({30'h0, seen_bank}, 32'h0);
        wr(8'h34, 32'h8);
        wr(8'h08, 32'h3);
        clr();
        wr(8'h18, 32'h8);
        repeat (8) @(posedge pclk);
        check({30'h0, seen_bank}, 32'h1);
        check(seen_pin, 32'h8);
        wr(8'h34, 32'h8);
        // Low power freezes pins and events
        low_power <= 1'b1;
        clr();
        wr(8'h1C, 32'h8);
        edge_to(32'hABCE_0000);
        edge_to(32'hABCD_0000);
        repeat (8) @(posedge pclk);
        check(pins_out, 32'h0000_D609);
        check(seen_pin, 32'h0);
        rc(8'h34, 32'h0);
        rc(8'h14, 32'h0000_D601);
        low_power <= 1'b0;
        repeat (4) @(posedge pclk);
        check(pins_out, 32'h0000_D601);
        wr(8'h30, 32'h8);
        rc(8'h2C, 32'h0002_0000);
        wr(8'h18, 32'h8);
        repeat (8) @(posedge pclk);
        @(posedge pclk);
        pwr_reset <= 1'b1;
        @(posedge pclk);
        pwr_reset <= 1'b0;
        rc(8'h10, 32'hFFFF_FFFF);
        rc(8'h24, 32'h0);
        rc(8'h2C, 32'h0);
        rc(8'h08, 32'h0);
        rc(8'h34, 32'h0);
        rc(8'h14, 32'h0000_D609);
        wr(8'h10, 32'h0);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        check(pins_oe_n, 32'hFFFF_FFFF);
        rc(8'h10, 32'hFFFF_FFFF);
        rc(8'h14, 32'h0);
        results();
    end
endmodule
